/* rtl/pstr_pkg.sv */
// Package of constants shared by the program stack and table read block.
package pstr_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned STACK_DEPTH   = 12;      // One of 4, 8 or 12 levels.
  localparam int unsigned PC_WIDTH      = 14;      // 12K words need 14 address bits.
  localparam int unsigned WORD_WIDTH    = 16;      // Program word width, 14 to 16.
  localparam int unsigned PROG_WORDS    = 12288;   // Program memory depth.
  localparam int unsigned BANK_WORDS    = 8192;    // Words reachable in one bank.
  localparam int unsigned PAGE_BITS     = 8;       // A page spans 256 locations.
  localparam int unsigned PTR_WIDTH     = $clog2(STACK_DEPTH + 1);
  localparam int unsigned BANK_SEL_BIT  = 5;       // Bank select bit of bank_pointer.
  localparam int unsigned SER_CMD_BITS  = 4;       // Serial command field width.
  localparam int unsigned SER_ADDR_BITS = 14;      // Serial address field width.
  localparam int unsigned SER_FRAME     = SER_CMD_BITS + SER_ADDR_BITS + WORD_WIDTH;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [PC_WIDTH-1:0]  RESET_VECTOR = 14'h0000;
  localparam logic [PTR_WIDTH-1:0] PTR_EMPTY    = 4'h0;

  // ----------------------------------------------------------------------
  // Serial commands
  // ----------------------------------------------------------------------
  localparam logic [SER_CMD_BITS-1:0] CMD_PROG_WR = 4'h1;
  localparam logic [SER_CMD_BITS-1:0] CMD_PROG_RD = 4'h2;
  localparam logic [SER_CMD_BITS-1:0] CMD_EE_WR   = 4'h3;
  localparam logic [SER_CMD_BITS-1:0] CMD_EE_RD   = 4'h4;

  typedef enum logic [1:0] {
    PSTR_OP_NONE,
    PSTR_OP_TABLE,
    PSTR_OP_TABLE_LAST
  } pstr_tbl_op_t;

endpackage : pstr_pkg

/* rtl/pstr_program_flow.sv */
// Program counter, return stack control, table read and serial programming.
module pstr_program_flow
  import pstr_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   cycleEn,
  input  wire logic                   callReq,
  input  wire logic [PC_WIDTH-1:0]    callTarget,
  input  wire logic                   jumpReq,
  input  wire logic                   pcLowWrite,
  input  wire logic [7:0]             pcLowData,
  input  wire logic                   returnReq,
  input  wire logic                   intPending,
  input  wire logic                   intEnable,
  input  wire logic [PC_WIDTH-1:0]    intVector,
  input  wire logic [7:0]             bankPointer,
  input  wire logic [7:0]             tableLowPtr,
  input  wire logic [7:0]             tableHighPtr,
  input  wire pstr_tbl_op_t           tableOp,
  input  wire logic                   aluWrite,
  input  wire logic                   aluCarry,
  input  wire logic                   aluZero,
  input  wire logic                   aluOverflow,
  input  wire logic [WORD_WIDTH-1:0]  progWord,
  input  wire logic                   reset_pin_n,
  input  wire logic                   program_serial_clock_pin,
  input  wire logic                   program_serial_data_pin_i,
  input  wire logic [WORD_WIDTH-1:0]  serReadData,
  output logic      [PC_WIDTH-1:0]    progAddr,
  output logic                        progBank,
  output logic      [PC_WIDTH-1:0]    pcOut,
  output logic                        intAck,
  output logic                        intFlag,
  output logic                        tableBusy,
  output logic                        tableDataValid,
  output logic      [7:0]             tableData,
  output logic      [7:0]             table_high_byte,
  output logic      [2:0]             statusFlags,
  output logic                        serActive,
  output logic                        serWrite,
  output logic                        serEeprom,
  output logic      [SER_ADDR_BITS-1:0] serAddr,
  output logic      [WORD_WIDTH-1:0]  serWriteData,
  output logic                        serStrobe,
  output logic                        program_serial_data_pin_o,
  output logic                        program_serial_data_pin_oe
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Page base of an address; the low 8 bits are the offset inside a page.
  function automatic logic [PC_WIDTH-1:0] page_join(input logic [PC_WIDTH-1:0] base,
                                                    input logic [7:0] offset);
    page_join = {base[PC_WIDTH-1:PAGE_BITS], offset};
  endfunction : page_join

  localparam logic [PC_WIDTH-1:0] LAST_ADDR = PC_WIDTH'(PROG_WORDS - 1);

  logic [PC_WIDTH-1:0] pc_q;
  logic [PC_WIDTH-1:0] stackTop;
  logic                stackFull;
  logic                stackEmpty;
  logic                pushNow;
  logic                popNow;
  logic                ackNow;
  logic                tblPhase_q;
  pstr_tbl_op_t        tblOp_q;
  logic [PC_WIDTH-1:0] tblAddr;

  // Acknowledge is withheld while the stack is full; the flag stays latched.
  assign ackNow  = cycleEn && intFlag && !stackFull && !tblPhase_q;
  assign pushNow = cycleEn && (callReq || ackNow) && !tblPhase_q;
  assign popNow  = cycleEn && returnReq && !ackNow && !tblPhase_q;

  // ----------------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------------
  // Not mapped anywhere; only push and pop reach it.
  pstr_return_stack u_stack (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .push     (pushNow),
    .pop      (popNow),
    .pushData (pc_q),
    .topData  (stackTop),
    .full     (stackFull),
    .empty    (stackEmpty)
  );

  // ----------------------------------------------------------------------
  // Interrupt latch and acknowledge
  // ----------------------------------------------------------------------
  // A new request wins over the clear by acknowledge, so none is lost.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      intFlag <= 1'b0;
      intAck  <= 1'b0;
    end else begin
      intAck <= ackNow;
      if (intPending && intEnable) begin
        intFlag <= 1'b1;
      end else if (ackNow) begin
        intFlag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------------
  // Interrupt outranks call, return, jumps; a table read holds the PC.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc_q <= RESET_VECTOR;
    end else if (cycleEn && !tblPhase_q) begin
      if (ackNow) begin
        pc_q <= intVector;
      end else if (callReq || jumpReq) begin
        pc_q <= callTarget;
      end else if (returnReq && !stackEmpty) begin
        pc_q <= stackTop;
      end else if (pcLowWrite) begin
        pc_q <= page_join(pc_q, pcLowData);
      end else if (tableOp == PSTR_OP_NONE) begin
        pc_q <= (pc_q == LAST_ADDR) ? RESET_VECTOR : pc_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Table read sequencing
  // ----------------------------------------------------------------------
  // First cycle latches the kind of read; the second returns the word.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tblPhase_q <= 1'b0;
      tblOp_q    <= PSTR_OP_NONE;
    end else if (cycleEn) begin
      if (!tblPhase_q && tableOp != PSTR_OP_NONE && !ackNow) begin
        tblPhase_q <= 1'b1;
        tblOp_q    <= tableOp;
      end else begin
        tblPhase_q <= 1'b0;
      end
    end
  end

  // The pointer pair is the full address; page modes take only the low byte.
  always_comb begin
    if (tblOp_q == PSTR_OP_TABLE_LAST) begin
      tblAddr = page_join(LAST_ADDR, tableLowPtr);
    end else if (tblOp_q == PSTR_OP_TABLE && tableHighPtr == 8'h00) begin
      tblAddr = page_join(pc_q, tableLowPtr);
    end else begin
      tblAddr = PC_WIDTH'({tableHighPtr, tableLowPtr});
    end
  end

  // Memory address: table address during the second cycle, else the PC.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      progAddr <= RESET_VECTOR;
      progBank <= 1'b0;
      pcOut    <= RESET_VECTOR;
    end else begin
      progAddr <= tblPhase_q ? tblAddr : pc_q;
      progBank <= bankPointer[BANK_SEL_BIT];
      pcOut    <= pc_q;
    end
  end

  // The high byte register has no write port; only a table read loads it.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tableData       <= 8'h00;
      table_high_byte <= 8'h00;
      tableDataValid  <= 1'b0;
      tableBusy       <= 1'b0;
    end else begin
      tableBusy      <= tblPhase_q;
      tableDataValid <= cycleEn && tblPhase_q;
      if (cycleEn && tblPhase_q) begin
        tableData       <= progWord[7:0];
        table_high_byte <= 8'(progWord[WORD_WIDTH-1:8]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  // Carry, zero and overflow move in the same cycle as the result write.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      statusFlags <= 3'h0;
    end else if (aluWrite) begin
      statusFlags <= {aluOverflow, aluZero, aluCarry};
    end
  end

  // ----------------------------------------------------------------------
  // Serial programming port
  // ----------------------------------------------------------------------
  // Pins come from the programmer, so each passes two flip-flops first.
  logic [1:0] rstSync_q;
  logic [1:0] clkSync_q;
  logic [1:0] datSync_q;
  logic       clkPrev_q;
  logic [SER_FRAME-1:0] shift_q;
  logic [5:0] bitCnt_q;
  logic [WORD_WIDTH-1:0] outShift_q;
  logic       readPhase_q;

  always_ff @(posedge ref_clk) begin
    rstSync_q <= {rstSync_q[0], reset_pin_n};
    clkSync_q <= {clkSync_q[0], program_serial_clock_pin};
    datSync_q <= {datSync_q[0], program_serial_data_pin_i};
  end

  // Frame: command, address, data, msb first on rising clock; a read
  // frame then shifts the word out on falling edges. Limitation: the
  // serial clock must be far slower than ref_clk.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clkPrev_q   <= 1'b0;
      serActive   <= 1'b0;
      bitCnt_q    <= 6'h00;
      shift_q     <= '0;
      serStrobe   <= 1'b0;
      serWrite    <= 1'b0;
      serEeprom   <= 1'b0;
      serAddr     <= '0;
      serWriteData <= '0;
      outShift_q  <= '0;
      readPhase_q <= 1'b0;
      program_serial_data_pin_o  <= 1'b0;
      program_serial_data_pin_oe <= 1'b0;
    end else begin
      clkPrev_q <= clkSync_q[1];
      serStrobe <= 1'b0;
      serActive <= !rstSync_q[1];
      if (rstSync_q[1]) begin
        bitCnt_q    <= 6'h00;
        readPhase_q <= 1'b0;
        program_serial_data_pin_oe <= 1'b0;
      end else if (clkSync_q[1] && !clkPrev_q && !readPhase_q) begin
        shift_q  <= {shift_q[SER_FRAME-2:0], datSync_q[1]};
        bitCnt_q <= (bitCnt_q == 6'(SER_FRAME - 1)) ? 6'h00 : bitCnt_q + 1'b1;
        if (bitCnt_q == 6'(SER_FRAME - 1)) begin
          serStrobe    <= 1'b1;
          serAddr      <= shift_q[SER_ADDR_BITS+WORD_WIDTH-2:WORD_WIDTH-1];
          serWriteData <= {shift_q[WORD_WIDTH-2:0], datSync_q[1]};
          serWrite  <= shift_q[SER_FRAME-2:SER_FRAME-1-SER_CMD_BITS] inside
                       {CMD_PROG_WR, CMD_EE_WR};
          serEeprom <= shift_q[SER_FRAME-2:SER_FRAME-1-SER_CMD_BITS] inside
                       {CMD_EE_WR, CMD_EE_RD};
          readPhase_q <= shift_q[SER_FRAME-2:SER_FRAME-1-SER_CMD_BITS] inside
                         {CMD_PROG_RD, CMD_EE_RD};
        end
      end else if (readPhase_q && serStrobe) begin
        outShift_q <= serReadData;
      end else if (readPhase_q && !clkSync_q[1] && clkPrev_q) begin
        program_serial_data_pin_oe <= 1'b1;
        program_serial_data_pin_o  <= outShift_q[WORD_WIDTH-1];
        outShift_q <= {outShift_q[WORD_WIDTH-2:0], 1'b0};
        bitCnt_q   <= (bitCnt_q == 6'(WORD_WIDTH)) ? 6'h00 : bitCnt_q + 1'b1;
        if (bitCnt_q == 6'(WORD_WIDTH)) begin
          readPhase_q <= 1'b0;
          program_serial_data_pin_oe <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_table_start;
    cycleEn && !tblPhase_q && tableOp != PSTR_OP_NONE && !ackNow;
  endsequence

  // The second instruction cycle of a table read is the next enable in phase two.
  sequence s_table_second;
    cycleEn && tblPhase_q;
  endsequence

  a_ack_when_full: assert property (@(posedge ref_clk) disable iff (reset)
    stackFull |-> !ackNow) else $error("Interrupt acknowledged with full stack.");

  a_table_two_cycles: assert property (@(posedge ref_clk) disable iff (reset)
    s_table_start |=> tblPhase_q)
    else $error("Table read did not enter its second cycle.");

  a_table_finish: assert property (@(posedge ref_clk) disable iff (reset)
    s_table_second |=> tableDataValid && !tblPhase_q)
    else $error("Table read did not finish in its second cycle.");

  a_reset_vector: assert property (@(posedge ref_clk)
    reset |=> pc_q == RESET_VECTOR) else $error("PC not at reset vector.");

  a_return_reload: assert property (@(posedge ref_clk) disable iff (reset)
    popNow && !callReq && !jumpReq && !stackEmpty |=> pc_q == $past(stackTop))
    else $error("Return did not reload the PC.");

  a_push_saves_pc: assert property (@(posedge ref_clk) disable iff (reset)
    pushNow && !popNow |=> stackTop == $past(pc_q))
    else $error("Push did not save the PC.");

  a_flag_latched: assert property (@(posedge ref_clk) disable iff (reset)
    intPending && intEnable |=> intFlag) else $error("Interrupt flag not latched.");

  a_high_byte_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !(cycleEn && tblPhase_q) |=> $stable(table_high_byte))
    else $error("High table byte changed outside a table read.");

  a_bank_select: assert property (@(posedge ref_clk) disable iff (reset)
    1'b1 |=> progBank == $past(bankPointer[BANK_SEL_BIT]))
    else $error("Bank select does not follow the bank pointer.");

  a_status_update: assert property (@(posedge ref_clk) disable iff (reset)
    aluWrite |=> statusFlags == $past({aluOverflow, aluZero, aluCarry}))
    else $error("Status flags not updated with the result.");

endmodule : pstr_program_flow

/* rtl/pstr_return_stack.sv */
// Hidden return address stack with overflow dropping the oldest entry.
module pstr_return_stack
  import pstr_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 push,
  input  wire logic                 pop,
  input  wire logic [PC_WIDTH-1:0]  pushData,
  output logic      [PC_WIDTH-1:0]  topData,
  output logic                      full,
  output logic                      empty
);

  logic [PC_WIDTH-1:0]  entry_q [STACK_DEPTH];
  logic [PTR_WIDTH-1:0] level_q;

  // ----------------------------------------------------------------------
  // Level pointer
  // ----------------------------------------------------------------------
  // Level counts live entries; zero is the bottom, the empty condition.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level_q <= PTR_EMPTY;
    end else if (push && !pop && level_q != PTR_WIDTH'(STACK_DEPTH)) begin
      level_q <= level_q + 1'b1;
    end else if (pop && !push && level_q != PTR_EMPTY) begin
      level_q <= level_q - 1'b1;
    end
  end

  // Entries shift down on push; a push when full drops the oldest at the bottom.
  always_ff @(posedge ref_clk) begin
    if (push && !pop) begin
      entry_q[0] <= pushData;
      for (int i = 1; i < STACK_DEPTH; i++) begin
        entry_q[i] <= entry_q[i-1];
      end
    end else if (pop && !push) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        entry_q[i] <= entry_q[i+1];
      end
    end
  end

  assign topData = entry_q[0];
  assign full    = (level_q == PTR_WIDTH'(STACK_DEPTH));
  assign empty   = (level_q == PTR_EMPTY);

endmodule : pstr_return_stack

/* sim/program_stack_table_read_test.sv */
// Self-checking bench for the program flow block.
module program_stack_table_read_test
  import pstr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------------
  logic                   ref_clk, reset, cycleEn, callReq, jumpReq, pcLowWrite, returnReq;
  logic                   intPending, intEnable, aluWrite, aluCarry, aluZero, aluOverflow;
  logic                   reset_pin_n, program_serial_clock_pin, program_serial_data_pin_i;
  logic [PC_WIDTH-1:0]    callTarget, intVector, progAddr, pcOut;
  logic [7:0]             pcLowData, bankPointer, tableLowPtr, tableHighPtr, tableData;
  logic [7:0]             table_high_byte;
  pstr_tbl_op_t           tableOp;
  logic [WORD_WIDTH-1:0]  progWord, serWriteData;
  logic [WORD_WIDTH-1:0]  serReadData;
  logic                   progBank, intAck, intFlag, tableBusy, tableDataValid, serActive;
  logic                   serWrite, serEeprom, serStrobe;
  logic                   program_serial_data_pin_o, program_serial_data_pin_oe;
  logic [2:0]             statusFlags, stM;
  logic [SER_ADDR_BITS-1:0] serAddr;
  logic [31:0]            seed, v;
  logic [PC_WIDTH-1:0]    pcM;
  logic                   flagM;
  logic [PC_WIDTH-1:0]    stk[$];
  int                     errorCnt, checkCount, strobeCnt, i;

  pstr_program_flow i_dut (.ref_clk, .reset, .cycleEn, .callReq, .callTarget, .jumpReq,
    .pcLowWrite, .pcLowData, .returnReq, .intPending, .intEnable, .intVector, .bankPointer,
    .tableLowPtr, .tableHighPtr, .tableOp, .aluWrite, .aluCarry, .aluZero, .aluOverflow,
    .progWord, .reset_pin_n, .program_serial_clock_pin, .program_serial_data_pin_i,
    .serReadData, .progAddr, .progBank, .pcOut, .intAck, .intFlag, .tableBusy,
    .tableDataValid, .tableData, .table_high_byte, .statusFlags, .serActive, .serWrite,
    .serEeprom, .serAddr, .serWriteData, .serStrobe, .program_serial_data_pin_o,
    .program_serial_data_pin_oe);

  pstr_prog_mem_model i_mem (.progAddr, .progWord);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Clock of 20 ns; strobes are counted here because they can land mid-bit.
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (serStrobe === 1'b1) strobeCnt <= strobeCnt + 1;

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function logic [15:0] wordOf(input logic [PC_WIDTH-1:0] a);
    return {a[13:6], a[7:0] ^ 8'hA5};
  endfunction : wordOf

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task finish_test();
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task push(input logic [PC_WIDTH-1:0] p);
    stk.push_back(p);
    if (stk.size() > STACK_DEPTH) void'(stk.pop_front());
  endtask : push

  // One instruction cycle; random ALU and bank inputs ride along with it.
  task issue(input logic c, j, r, pl, input logic [PC_WIDTH-1:0] tgt, input logic [7:0] lo);
    logic ack, saw;
    v = rnd();
    @(posedge ref_clk);
    {cycleEn, callReq, jumpReq, returnReq, pcLowWrite} <= {1'b1, c, j, r, pl};
    {callTarget, pcLowData, bankPointer} <= {tgt, lo, v[7:0]};
    {aluWrite, aluCarry, aluZero, aluOverflow} <= v[11:8];
    @(posedge ref_clk);
    {cycleEn, callReq, jumpReq, returnReq, pcLowWrite, aluWrite} <= 6'h00;
    ack = flagM && stk.size() < STACK_DEPTH;
    if (ack) flagM = 0;
    #1 saw = intAck;
    repeat (2) begin
      @(posedge ref_clk);
      #1 saw |= intAck;
    end
    if (ack) begin
      push(pcM);
      pcM = intVector;
    end else if (c) begin
      push(pcM);
      pcM = tgt;
    end else if (j) pcM = tgt;
    else if (r) pcM = stk.pop_back();
    else if (pl) pcM = {pcM[13:8], lo};
    else pcM++;
    if (v[11]) stM = {v[8], v[9], v[10]};
    check("pcOut", 32'(pcM), 32'(pcOut));
    check("intAck", 32'(ack), 32'(saw));
    check("progBank", 32'(v[5]), 32'(progBank));
    check("statusFlags", 32'(stM), 32'(statusFlags));
  endtask : issue

  // Table read spread over two instruction cycles.
  task tread(input pstr_tbl_op_t op, input logic [7:0] hi, input logic [7:0] lo);
    logic [PC_WIDTH-1:0] a;
    logic seen, got;
    a = (op == PSTR_OP_TABLE_LAST) ? {6'h2F, lo} : (hi == 0) ? {pcM[13:8], lo} : {hi[5:0], lo};
    @(posedge ref_clk);
    {cycleEn, tableOp, tableHighPtr, tableLowPtr} <= {1'b1, op, hi, lo};
    @(posedge ref_clk);
    {cycleEn, tableOp} <= {1'b0, PSTR_OP_NONE};
    seen = 0;
    repeat (2) begin
      @(posedge ref_clk);
      #1 seen |= tableDataValid;
    end
    @(posedge ref_clk);
    cycleEn <= 1;
    #1 seen |= tableDataValid;
    @(posedge ref_clk);
    cycleEn <= 0;
    #1 got = tableDataValid;
    repeat (2) begin
      @(posedge ref_clk);
      #1 got |= tableDataValid;
    end
    check("early valid", 0, 32'(seen));
    check("valid", 1, 32'(got));
    check("tableData", 32'(wordOf(a)), 32'({table_high_byte, tableData}));
    check("high byte", 32'(wordOf(a) >> 8), 32'(table_high_byte));
  endtask : tread

  // Programmer side: data changes while the serial clock is low, msb first.
  task serFrame(input logic [SER_CMD_BITS-1:0] cmd, input logic [13:0] ad, input logic [15:0] dt);
    logic [SER_FRAME-1:0] fr;
    int n;
    fr = {cmd, ad, dt};
    n = strobeCnt;
    for (int b = SER_FRAME - 1; b >= 0; b--) begin
      @(posedge ref_clk) program_serial_data_pin_i <= fr[b];
      repeat (4) @(posedge ref_clk);
      program_serial_clock_pin <= 1;
      repeat (4) @(posedge ref_clk);
      program_serial_clock_pin <= 0;
      program_serial_data_pin_i <= ~fr[b];
    end
    repeat (8) @(posedge ref_clk);
    check("strobes", 32'(n + 1), 32'(strobeCnt));
    check("write", 32'(cmd == CMD_PROG_WR || cmd == CMD_EE_WR), 32'(serWrite));
    check("eeprom", 32'(cmd == CMD_EE_WR || cmd == CMD_EE_RD), 32'(serEeprom));
    check("addr", 32'(ad), 32'(serAddr));
    check("data", 32'(dt), 32'(serWriteData));
    check("oe", 32'(cmd == CMD_PROG_RD || cmd == CMD_EE_RD),
          32'(program_serial_data_pin_oe));
  endtask : serFrame

  // Programmer reads the word back: one bit stands before each further clock pulse.
  task serRead(input logic [15:0] exp);
    logic [15:0] got;
    for (int b = 15; b >= 0; b--) begin
      @(posedge ref_clk) program_serial_clock_pin <= 1;
      #1 got[b] = program_serial_data_pin_o;
      repeat (4) @(posedge ref_clk);
      program_serial_clock_pin <= 0;
      repeat (4) @(posedge ref_clk);
    end
    check("read word", 32'(exp), 32'(got));
    check("oe off", 0, 32'(program_serial_data_pin_oe));
  endtask : serRead

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'h0a4b_9bda;
    {reset, cycleEn, callReq, jumpReq, pcLowWrite, returnReq, intPending, intEnable} = 8'h80;
    {aluWrite, aluCarry, aluZero, aluOverflow, program_serial_clock_pin} = 5'h00;
    {reset_pin_n, program_serial_data_pin_i, serReadData, intVector} = {1'b1, 1'b0, 16'h0, 14'h0};
    {callTarget, pcLowData, bankPointer, tableLowPtr, tableHighPtr} = 0;
    tableOp = PSTR_OP_NONE;
    {errorCnt, checkCount, strobeCnt, stM, pcM, flagM} = 0;
    repeat (2) @(posedge ref_clk);
    reset <= 0;
    @(posedge ref_clk);
    #1 check("reset pc", 0, 32'(pcOut));
    check("reset flag", 0, 32'(intFlag));
    repeat (40) begin
      v = rnd();
      case (v[2:0])
        3'd0: issue(1, 0, 0, 0, {1'b0, v[24:12]}, 8'h00);
        3'd1: issue(0, 1, 0, 0, {1'b0, v[24:12]}, 8'h00);
        3'd2: issue(0, 0, stk.size() > 0, 0, 14'h0000, 8'h00);
        3'd3: issue(0, 0, 0, 1, 14'h0000, v[31:24]);
        default: issue(0, 0, 0, 0, 14'h0000, 8'h00);
      endcase
    end
    for (i = 0; i < STACK_DEPTH + 2; i++) issue(1, 0, 0, 0, 14'(i * 300 + 7), 8'h00);
    @(posedge ref_clk);
    {intPending, intEnable, intVector} <= {2'b11, 14'h0004};
    flagM = 1;
    issue(0, 0, 0, 0, 14'h0000, 8'h00);
    check("flag held", 1, 32'(intFlag));
    @(posedge ref_clk);
    intPending <= 0;
    issue(0, 0, 1, 0, 14'h0000, 8'h00);
    issue(0, 0, 0, 0, 14'h0000, 8'h00);
    while (stk.size() > 0) issue(0, 0, 1, 0, 14'h0000, 8'h00);
    issue(0, 1, 0, 0, 14'h0523, 8'h00);
    for (i = 0; i < 9; i++) begin
      v = rnd();
      if (i % 3 == 0) tread(PSTR_OP_TABLE, 8'h00, v[7:0]);
      else if (i % 3 == 1) tread(PSTR_OP_TABLE, 8'(v[13:8] % 47 + 1), v[7:0]);
      else tread(PSTR_OP_TABLE_LAST, v[15:8], v[7:0]);
    end
    @(posedge ref_clk) reset_pin_n <= 0;
    repeat (4) @(posedge ref_clk);
    v = rnd();
    serFrame(CMD_PROG_WR, v[13:0], v[31:16]);
    serFrame(CMD_EE_WR, v[27:14], v[15:0]);
    serReadData <= v[31:16];
    serFrame(CMD_PROG_RD, v[13:0], v[15:0]);
    serRead(v[31:16]);
    finish_test();
  end

  // Watchdog: the whole run needs well under 5000 cycles.
  initial begin
    repeat (5000) @(posedge ref_clk);
    errorCnt++;
    finish_test();
  end
endmodule : program_stack_table_read_test

/* sim/pstr_prog_mem_model.sv */
// Program memory model that answers the block's fetch address.
module pstr_prog_mem_model
  import pstr_pkg::*;
(
  input  wire logic [PC_WIDTH-1:0]   progAddr,
  output logic      [WORD_WIDTH-1:0] progWord
);
  timeunit 1ns;
  timeprecision 1ns;

  // Every word mixes in its address, so a wrong table address can never match by luck.
  assign progWord = {progAddr[13:6], progAddr[7:0] ^ 8'hA5};
endmodule : pstr_prog_mem_model
